// ---- rtl/e1_line_global_tx_config_regs.sv ----
`timescale 1ns/100ps
module e1_line_global_tx_config_regs
  import e1_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irqActive,
  output logic intPinOut,
  output logic intPinOe,
  input wire logic txLineClock,
  input wire logic txSingleRailIn,
  input wire logic [1:0] txDualRailIn,
  output logic [1:0] txData,
  output logic txDataValid,
  output cfgOut_t cfg
);

  // --------------------------------------------------------------------
  // Reset synchroniser
  // --------------------------------------------------------------------
  logic rstMeta_r;
  logic rstSyncN;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_r <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSyncN <= rstMeta_r;
    end
  end

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  logic hitGlobal;
  logic hitTerm;
  logic hitJitter;
  logic hitTx0;
  logic hitTx1;
  logic hitAny;
  logic setupPhase;
  logic wrDone;
  logic wrLane;
  logic [7:0] wByte;
  logic [7:0] rdSel;

  assign hitGlobal = paddr == byteAddr(IDX_GLOBAL);
  assign hitTerm = paddr == byteAddr(IDX_TERM);
  assign hitJitter = paddr == byteAddr(IDX_JITTER);
  assign hitTx0 = paddr == byteAddr(IDX_TX0);
  assign hitTx1 = paddr == byteAddr(IDX_TX1);
  assign hitAny = hitGlobal | hitTerm | hitJitter | hitTx0 | hitTx1;
  assign setupPhase = psel & ~penable;
  // Every access completes in its first access cycle.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hitAny;
  assign wrLane = pstrb[0];
  assign wrDone = psel & penable & pwrite & hitAny & wrLane;
  assign wByte = pwdata[7:0];

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  // Reserved positions are masked to zero on every write and reset to zero, so they always read as zero.
  logic [7:0] global_r;
  logic [7:0] term_r;
  logic [7:0] jitter_r;
  logic [7:0] tx0_r;
  logic [7:0] tx1_r;

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      global_r <= RST_GLOBAL;
      term_r <= RST_TERM;
      jitter_r <= RST_JITTER;
      tx0_r <= RST_TX0;
      tx1_r <= RST_TX1;
    end else if (wrDone) begin
      if (hitGlobal) begin
        global_r <= wByte & MASK_GLOBAL;
      end
      if (hitTerm) begin
        term_r <= wByte & MASK_TERM;
      end
      if (hitJitter) begin
        jitter_r <= wByte & MASK_JITTER;
      end
      if (hitTx0) begin
        tx0_r <= wByte & MASK_TX0;
      end
      if (hitTx1) begin
        tx1_r <= wByte & MASK_TX1;
      end
    end
  end

  assign rdSel = hitGlobal ? global_r :
                 hitTerm ? term_r :
                 hitJitter ? jitter_r :
                 hitTx0 ? tx0_r :
                 hitTx1 ? tx1_r : 8'h00;

  // Read data is caught in the setup cycle and stands through the access.
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      prdata <= 32'h0000_0000;
    end else if (setupPhase) begin
      prdata <= {24'h00_0000, rdSel};
    end
  end

  // --------------------------------------------------------------------
  // Field decode
  // --------------------------------------------------------------------
  globalReg_t gReg;
  termReg_t tReg;
  jitterReg_t jReg;
  tx0Reg_t x0Reg;
  tx1Reg_t x1Reg;
  intStyle_t intStyle;
  logic rsvTemplate;

  assign gReg = global_r;
  assign tReg = term_r;
  assign jReg = jitter_r;
  assign x0Reg = tx0_r;
  assign x1Reg = tx1_r;

  function automatic term_t termDecode(input logic [2:0] code);
    if (code[2]) begin
      return TERM_EXT;
    end else if (code[0]) begin
      return TERM_120;
    end
    return TERM_75;
  endfunction

  // Codes 010 and 011 are not defined; 010 falls back to the 75 ohm match and 011 to the 120 ohm match.
  assign cfg.txTerm = termDecode(tReg.txTerm);
  assign cfg.rxTerm = termDecode(tReg.rxTerm);

  assign intStyle = !gReg.intPinStyle[0] ? PIN_OD_LOW :
                    gReg.intPinStyle[1] ? PIN_PP_HIGH : PIN_PP_LOW;

  assign cfg.jaPos = !jReg.jitterPositionSel[0] ? JA_OFF :
                     jReg.jitterPositionSel[1] ? JA_RX : JA_TX;
  assign cfg.jaLimitMode = jReg.jitterLimitMode;
  assign cfg.jaDepth = jReg.jitterDepthSel[1] ? DEPTH_32 :
                       jReg.jitterDepthSel[0] ? DEPTH_64 : DEPTH_128;
  assign cfg.jaNarrowBw = jReg.jitterBandwidthSel;

  assign cfg.txPowerUp = ~x0Reg.txOff;
  // The float bit leaves the rest of the transmit path running.
  assign cfg.lineDriverEn = ~x0Reg.txOff & ~x1Reg.lineDriverFloat;
  assign cfg.txMode = x0Reg.txCodingMode[1] ? CODE_BYPASS :
                      x0Reg.txCodingMode[0] ? CODE_AMI : CODE_HDB3;
  assign cfg.dfmEnable = ~x1Reg.driverFaultMonitorDisable;

  assign rsvTemplate = (x1Reg.pulseTemplateSel >= TPL_RSV_FIRST) &&
                       (x1Reg.pulseTemplateSel <= TPL_RSV_LAST);
  assign cfg.tpl = (x1Reg.pulseTemplateSel == 4'h0) ? TPL_75 :
                   (x1Reg.pulseTemplateSel == 4'h1) ? TPL_120 :
                   rsvTemplate ? TPL_RSV : TPL_USER;

  // --------------------------------------------------------------------
  // Submodules
  // --------------------------------------------------------------------
  int_pin_drive intDrive (
    .clk(clk),
    .rstSyncN(rstSyncN),
    .irqActive(irqActive),
    .style(intStyle),
    .intPinOut(intPinOut),
    .intPinOe(intPinOe)
  );

  // Power-down masks the sample strobe rather than the raw line clock, so the pin
  // reaches no logic ahead of its synchroniser. A powered-down transmitter hands out no samples.
  logic sampValid;
  assign txDataValid = sampValid & cfg.txPowerUp;

  tx_input_sampler txSampler (
    .clk(clk),
    .rstSyncN(rstSyncN),
    .txLineClock(txLineClock),
    .txSingleRailIn(txSingleRailIn),
    .txDualRailIn(txDualRailIn),
    .activeLow(x0Reg.txDataPolarity),
    .risingEdge(x0Reg.txClockEdgeSel),
    .mode(cfg.txMode),
    .txData(txData),
    .txDataValid(sampValid)
  );

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstSyncN);

  AST_WRITE_READBACK: assert property (
    (wrDone && hitJitter) |=> (jitter_r == ($past(wByte) & MASK_JITTER))
  ) else $error("jitter register did not take the write");

  AST_NO_WRITE_HOLD: assert property (
    !(wrDone && hitTx1) |=> $stable(tx1_r)
  ) else $error("register changed without a write");

  AST_READ_DATA: assert property (
    (setupPhase && hitTx0) |=> (prdata[7:0] == $past(tx0_r)) && (prdata[31:8] == 24'h00_0000)
  ) else $error("read data does not match the register");

  AST_UNMAPPED_ERR: assert property (
    (psel && penable && !hitAny) |-> pslverr ##1
      ($stable(global_r) && $stable(term_r) && $stable(jitter_r) && $stable(tx0_r) && $stable(tx1_r))
  ) else $error("unmapped access gave no error or changed a register");

  AST_OPEN_DRAIN: assert property (
    (!gReg.intPinStyle[0] && $stable(global_r)) ##1 $stable(global_r) |-> !intPinOut && (intPinOe == $past(irqActive))
  ) else $error("open drain pin drove high or misplaced enable");

  AST_PUSH_PULL_HIGH: assert property (
    (gReg.intPinStyle == 2'b11) ##1 (gReg.intPinStyle == 2'b11) |-> intPinOe && (intPinOut == $past(irqActive))
  ) else $error("push-pull high pin wrong");

  AST_TERM_EXT: assert property (
    tReg.txTerm[2] |-> (cfg.txTerm == TERM_EXT)
  ) else $error("external transmit termination not selected");

  AST_RX_TERM: assert property (
    (tReg.rxTerm == 3'b001) |-> (cfg.rxTerm == TERM_120)
  ) else $error("receive 120 ohm match not selected");

  AST_JA_POS: assert property (
    (jReg.jitterPositionSel == 2'b10) |-> (cfg.jaPos == JA_OFF)
  ) else $error("jitter attenuator should be unused");

  AST_JA_DEPTH: assert property (
    (jReg.jitterDepthSel == 2'b01) |-> (cfg.jaDepth == DEPTH_64)
  ) else $error("jitter depth not 64 bits");

  AST_POWER_DOWN: assert property (
    x0Reg.txOff |-> !cfg.lineDriverEn && !cfg.txPowerUp
  ) else $error("powered-down transmitter still drives");

  AST_FLOAT_ONLY: assert property (
    (x1Reg.lineDriverFloat && !x0Reg.txOff) |-> !cfg.lineDriverEn && cfg.txPowerUp
  ) else $error("float bit did more than float the driver");

  AST_MODE_BYPASS: assert property (
    x0Reg.txCodingMode[1] |-> (cfg.txMode == CODE_BYPASS)
  ) else $error("encoder bypass not selected");

  AST_DFM: assert property (
    (cfg.dfmEnable != x1Reg.driverFaultMonitorDisable)
  ) else $error("fault monitor enable wrong");

  AST_TEMPLATE_RSV: assert property (
    (x1Reg.pulseTemplateSel == 4'hb) |-> (cfg.tpl == TPL_RSV)
  ) else $error("template 1011 should be reserved");

  AST_TEMPLATE_USER: assert property (
    (x1Reg.pulseTemplateSel == 4'hc) |-> (cfg.tpl == TPL_USER)
  ) else $error("template 1100 should be user waveform");

  AST_BW: assert property (
    $rose(jReg.jitterBandwidthSel) |-> cfg.jaNarrowBw
  ) else $error("bandwidth select not followed");

  AST_POLARITY: assert property (
    sampValid |-> (txData == $past(txSampler.raw ^ {2{x0Reg.txDataPolarity}}))
  ) else $error("transmit data polarity not applied");

  AST_EDGE_SEL: assert property (
    sampValid |-> $past(txSampler.sync_r[3] == (x0Reg.txClockEdgeSel || (cfg.txMode != CODE_BYPASS)))
  ) else $error("transmit data taken on the wrong line clock edge");

  AST_PUSH_PULL_LOW: assert property (
    (gReg.intPinStyle == 2'b01) ##1 (gReg.intPinStyle == 2'b01) |-> intPinOe && (intPinOut == !$past(irqActive))
  ) else $error("push-pull low pin wrong");

  AST_TX_TERM_120: assert property (
    (tReg.txTerm == 3'b001) |-> (cfg.txTerm == TERM_120)
  ) else $error("transmit 120 ohm match not selected");

  AST_RX_TERM_EXT: assert property (
    tReg.rxTerm[2] |-> (cfg.rxTerm == TERM_EXT)
  ) else $error("external receive termination not selected");

  AST_JA_RX: assert property (
    (jReg.jitterPositionSel == 2'b11) |-> (cfg.jaPos == JA_RX)
  ) else $error("jitter attenuator not in receive path");

  AST_JA_DEPTH_32: assert property (
    jReg.jitterDepthSel[1] |-> (cfg.jaDepth == DEPTH_32)
  ) else $error("jitter depth not 32 bits");

  AST_BW_WIDE: assert property (
    !jReg.jitterBandwidthSel |-> !cfg.jaNarrowBw
  ) else $error("wide jitter bandwidth not selected");

  AST_MODE_AMI: assert property (
    (x0Reg.txCodingMode == 2'b01) |-> (cfg.txMode == CODE_AMI)
  ) else $error("AMI coding not selected");

  AST_TEMPLATE_75: assert property (
    (x1Reg.pulseTemplateSel == 4'h0) |-> (cfg.tpl == TPL_75)
  ) else $error("template 0000 should be the 75 ohm shape");

  AST_WRITE_TX1: assert property (
    (wrDone && hitTx1) |=> (tx1_r == ($past(wByte) & MASK_TX1))
  ) else $error("transmit driver register did not take the write");

  AST_READ_JITTER: assert property (
    (setupPhase && hitJitter) |=> (prdata[7:0] == $past(jitter_r))
  ) else $error("jitter read data does not match the register");

endmodule

// ---- shared/e1_cfg_pkg.sv ----
package e1_cfg_pkg;

  // --------------------------------------------------------------------
  // Register indices and bus addresses
  // --------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] IDX_GLOBAL = 8'h02;
  localparam logic [7:0] IDX_TERM = 8'h03;
  localparam logic [7:0] IDX_JITTER = 8'h04;
  localparam logic [7:0] IDX_TX0 = 8'h05;
  localparam logic [7:0] IDX_TX1 = 8'h06;

  function automatic logic [ADDR_W-1:0] byteAddr(input logic [7:0] idx);
    return {idx[ADDR_W-3:0], 2'b00};
  endfunction

  // --------------------------------------------------------------------
  // Reset values and writable masks
  // --------------------------------------------------------------------
  localparam logic [7:0] RST_GLOBAL = 8'h00;
  localparam logic [7:0] RST_TERM = 8'h00;
  localparam logic [7:0] RST_JITTER = 8'h20;
  localparam logic [7:0] RST_TX0 = 8'h00;
  localparam logic [7:0] RST_TX1 = 8'h10;
  localparam logic [7:0] MASK_GLOBAL = 8'h03;
  localparam logic [7:0] MASK_TERM = 8'h3f;
  localparam logic [7:0] MASK_JITTER = 8'h3f;
  localparam logic [7:0] MASK_TX0 = 8'h1f;
  localparam logic [7:0] MASK_TX1 = 8'h3f;

  // --------------------------------------------------------------------
  // Register layouts
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [5:0] rsv; logic [1:0] intPinStyle;
  } globalReg_t;
  typedef struct packed {
    logic [1:0] rsv; logic [2:0] txTerm; logic [2:0] rxTerm;
  } termReg_t;
  typedef struct packed {
    logic [1:0] rsv; logic jitterLimitMode; logic [1:0] jitterPositionSel;
    logic [1:0] jitterDepthSel; logic jitterBandwidthSel;
  } jitterReg_t;
  typedef struct packed {
    logic [2:0] rsv; logic txOff; logic txDataPolarity;
    logic txClockEdgeSel; logic [1:0] txCodingMode;
  } tx0Reg_t;
  typedef struct packed {
    logic [1:0] rsv; logic driverFaultMonitorDisable;
    logic lineDriverFloat; logic [3:0] pulseTemplateSel;
  } tx1Reg_t;

  // --------------------------------------------------------------------
  // Decoded modes
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {PIN_OD_LOW = 3'b001, PIN_PP_LOW = 3'b010, PIN_PP_HIGH = 3'b100} intStyle_t;
  typedef enum logic [2:0] {TERM_75 = 3'b001, TERM_120 = 3'b010, TERM_EXT = 3'b100} term_t;
  typedef enum logic [2:0] {JA_OFF = 3'b001, JA_TX = 3'b010, JA_RX = 3'b100} jaPos_t;
  typedef enum logic [2:0] {DEPTH_128 = 3'b001, DEPTH_64 = 3'b010, DEPTH_32 = 3'b100} jaDepth_t;
  typedef enum logic [2:0] {CODE_HDB3 = 3'b001, CODE_AMI = 3'b010, CODE_BYPASS = 3'b100} txMode_t;
  typedef enum logic [3:0] {
    TPL_75 = 4'b0001, TPL_120 = 4'b0010, TPL_RSV = 4'b0100, TPL_USER = 4'b1000
  } template_t;
  localparam logic [3:0] TPL_RSV_FIRST = 4'h2;
  localparam logic [3:0] TPL_RSV_LAST = 4'hb;

  typedef struct packed {
    term_t txTerm; term_t rxTerm;
    jaPos_t jaPos; jaDepth_t jaDepth;
    logic jaLimitMode; logic jaNarrowBw;
    logic txPowerUp; logic lineDriverEn;
    logic dfmEnable; txMode_t txMode; template_t tpl;
  } cfgOut_t;

endpackage

// ---- rtl/int_pin_drive.sv ----
`timescale 1ns/100ps
module int_pin_drive
  import e1_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rstSyncN,
  input wire logic irqActive,
  input intStyle_t style,
  output logic intPinOut,
  output logic intPinOe
);

  logic out_nxt;
  logic oe_nxt;

  // Open drain only pulls low while active and leaves the pull-up otherwise.
  assign out_nxt = (style == PIN_PP_HIGH) ? irqActive : (style == PIN_PP_LOW) ? ~irqActive : 1'b0;
  assign oe_nxt = (style == PIN_OD_LOW) ? irqActive : 1'b1;

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      intPinOut <= 1'b0;
      intPinOe <= 1'b0;
    end else begin
      intPinOut <= out_nxt;
      intPinOe <= oe_nxt;
    end
  end

endmodule

// ---- rtl/tx_input_sampler.sv ----
`timescale 1ns/100ps
module tx_input_sampler
  import e1_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rstSyncN,
  input wire logic txLineClock,
  input wire logic txSingleRailIn,
  input wire logic [1:0] txDualRailIn,
  input wire logic activeLow,
  input wire logic risingEdge,
  input txMode_t mode,
  output logic [1:0] txData,
  output logic txDataValid
);

  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic clkPrev_r;
  logic rise;
  logic fall;
  logic take;
  logic [1:0] raw;

  assign rise = sync_r[3] & ~clkPrev_r;
  assign fall = ~sync_r[3] & clkPrev_r;
  // Single rail data is always taken on the rising edge.
  assign take = (mode == CODE_BYPASS) ? (risingEdge ? rise : fall) : rise;
  assign raw = (mode == CODE_BYPASS) ? sync_r[1:0] : {1'b0, sync_r[2]};

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      meta_r <= 4'h0;
      sync_r <= 4'h0;
      clkPrev_r <= 1'b0;
      txData <= 2'b00;
      txDataValid <= 1'b0;
    end else begin
      meta_r <= {txLineClock, txSingleRailIn, txDualRailIn};
      sync_r <= meta_r;
      clkPrev_r <= sync_r[3];
      txDataValid <= take;
      if (take) begin
        txData <= raw ^ {2{activeLow}};
      end
    end
  end

endmodule

// ---- sim/lif_host_model.sv ----
`timescale 1ns/100ps
module lif_host_model
  import e1_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  logic timedOut = 1'b0;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h0;
  end

  // ------------------------------------------------------------------
  // Bus transfers
  // ------------------------------------------------------------------
  // The request stays put until pready is seen high at a rising edge, or for at most 64 edges.
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] wd,
                      input logic [3:0] st, output logic [7:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, wd};
    pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    timedOut = timedOut | (n >= 64);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reserved positions always go out as zero, which is their default.
  task automatic regWrite(input logic [7:0] idx, input logic [7:0] val);
    logic [7:0] m;
    logic [7:0] rd;
    logic err;
    case (idx)
      IDX_GLOBAL: m = 8'h03;
      IDX_TX0: m = 8'h1f;
      default: m = 8'h3f;
    endcase
    xfer(1'b1, ADDR_W'(idx << 2), val & m, 4'h1, rd, err);
  endtask

  // A 75 ohm cable needs a different template for internal and external matching.
  task automatic template75(input logic internalMatch, input logic [1:0] upper);
    regWrite(IDX_TX1, {2'b00, upper, 3'b000, ~internalMatch});
  endtask
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/100ps
module tb_top
  import e1_cfg_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, intPinOut, intPinOe, txDataValid;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic irqActive = 1'b0;
  logic txLineClock = 1'b0;
  logic txSingleRailIn = 1'b0;
  logic [1:0] txDualRailIn = 2'b00;
  logic [1:0] txData;
  cfgOut_t cfg;
  int errTotal = 0;
  int nCompared = 0;

  always #12.5 clk = ~clk;

  e1_line_global_tx_config_regs DUT (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irqActive(irqActive), .intPinOut(intPinOut), .intPinOe(intPinOe),
    .txLineClock(txLineClock), .txSingleRailIn(txSingleRailIn), .txDualRailIn(txDualRailIn),
    .txData(txData), .txDataValid(txDataValid), .cfg(cfg));
  lif_host_model host (.clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

  // ------------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] wd, input logic [3:0] st,
                     output logic [7:0] rd, output logic err);
    host.xfer(wr, a, wd, st, rd, err);
    if (host.timedOut) begin
      errTotal++;
      conclude();
    end
  endtask

  task automatic readChk(input logic [7:0] idx, input logic [7:0] exp, input string what);
    logic [7:0] rd;
    logic err;
    acc(1'b0, ADDR_W'(idx << 2), 8'h00, 4'h0, rd, err);
    check(what, {24'h0, rd}, {24'h0, exp});
  endtask

  task automatic setReg(input logic [7:0] idx, input logic [7:0] val);
    host.regWrite(idx, val);
    @(negedge clk);
  endtask

  task automatic pinCase(input logic [1:0] code, input logic irq, input logic expOe, input logic expOut);
    setReg(IDX_GLOBAL, {6'h00, code});
    @(posedge clk);
    irqActive <= irq;
    repeat (2) @(posedge clk);
    #1;
    check("intPinOe", {31'h0, intPinOe}, {31'h0, expOe});
    if (expOe) check("intPinOut", {31'h0, intPinOut}, {31'h0, expOut});
  endtask

  task automatic termCase(input logic [2:0] tx, input term_t txExp, input logic [2:0] rx, input term_t rxExp);
    setReg(IDX_TERM, {2'b00, tx, rx});
    check("txTerm", 32'(cfg.txTerm), 32'(txExp));
    check("rxTerm", 32'(cfg.rxTerm), 32'(rxExp));
  endtask

  // The window is long enough for the synchroniser delay of the line clock.
  task automatic lineEdge(input logic lvl, input logic [1:0] dual, input logic single,
                          input int expCount, input logic [1:0] expData, input string what);
    int n;
    logic [1:0] got;
    n = 0;
    got = 2'b00;
    @(posedge clk);
    txLineClock <= lvl;
    txDualRailIn <= dual;
    txSingleRailIn <= single;
    repeat (10) begin
      @(posedge clk);
      #1;
      if (txDataValid === 1'b1) begin
        n++;
        got = txData;
      end
    end
    check({what, " samples"}, 32'(n), 32'(expCount));
    if (expCount > 0) check(what, {30'h0, got}, {30'h0, expData});
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    conclude();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    logic [7:0] rd;
    logic err;
    logic [1:0] c;
    logic q;
    jaPos_t posExp[4];
    jaDepth_t depExp[4];
    txMode_t modeExp[4];
    logic [3:0] tplCode[4];
    template_t tplExp[4];
    posExp = '{JA_OFF, JA_TX, JA_OFF, JA_RX};
    depExp = '{DEPTH_128, DEPTH_64, DEPTH_32, DEPTH_32};
    modeExp = '{CODE_HDB3, CODE_AMI, CODE_BYPASS, CODE_BYPASS};
    tplCode = '{4'h2, 4'hb, 4'hc, 4'hf};
    tplExp = '{TPL_RSV, TPL_RSV, TPL_USER, TPL_USER};
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    readChk(IDX_GLOBAL, 8'h00, "global");
    readChk(IDX_TERM, 8'h00, "term");
    readChk(IDX_JITTER, 8'h20, "jitter");
    readChk(IDX_TX0, 8'h00, "tx0");
    readChk(IDX_TX1, 8'h10, "tx1");
    check("driverEn default", 32'(cfg.lineDriverEn), 32'h0);
    acc(1'b0, 8'h1c, 8'h00, 4'h0, rd, err);
    check("unmapped err", 32'(err), 32'h1);
    check("unmapped data", 32'(rd), 32'h0);
    acc(1'b1, 8'h04, 8'hff, 4'h1, rd, err);
    acc(1'b1, 8'h18, 8'h0f, 4'h0, rd, err);
    readChk(IDX_TX1, 8'h10, "tx1 no strobe");
    readChk(IDX_GLOBAL, 8'h00, "global after unmapped");
    acc(1'b1, 8'h14, 8'h1f, 4'h1, rd, err);
    readChk(IDX_TX0, 8'h1f, "tx0 readback");
    for (int i = 0; i < 8; i++) begin
      c = 2'(i >> 1);
      q = i[0];
      pinCase(c, q, c[0] ? 1'b1 : q, (c == 2'b11) ? q : ((c == 2'b01) ? ~q : 1'b0));
    end
    termCase(3'b000, TERM_75, 3'b001, TERM_120);
    termCase(3'b001, TERM_120, 3'b100, TERM_EXT);
    termCase(3'b111, TERM_EXT, 3'b000, TERM_75);
    for (int i = 0; i < 4; i++) begin
      setReg(IDX_JITTER, {2'b00, i[0], 2'(i), 2'(3 - i), i[1]});
      check("jaPos", 32'(cfg.jaPos), 32'(posExp[i]));
      check("jaDepth", 32'(cfg.jaDepth), 32'(depExp[3 - i]));
      check("jaLimit", 32'(cfg.jaLimitMode), 32'(i[0]));
      check("jitter_bandwidth_sel", 32'(cfg.jaNarrowBw), 32'(i[1]));
    end
    readChk(IDX_JITTER, 8'h39, "jitter readback");
    setReg(IDX_TX0, 8'h00);
    host.template75(1'b1, 2'b00);
    @(negedge clk);
    check("tpl 75", 32'(cfg.tpl), 32'(TPL_75));
    check("driverEn", 32'(cfg.lineDriverEn), 32'h1);
    host.template75(1'b0, 2'b10);
    @(negedge clk);
    check("tpl 120", 32'(cfg.tpl), 32'(TPL_120));
    check("driver_fault_monitor_disable", 32'(cfg.dfmEnable), 32'h0);
    setReg(IDX_TX1, 8'h00);
    for (int i = 0; i < 4; i++) begin
      setReg(IDX_TX0, {3'b000, i[0], 2'b00, 2'(i)});
      check("txMode", 32'(cfg.txMode), 32'(modeExp[i]));
      check("txPowerUp", 32'(cfg.txPowerUp), 32'(!i[0]));
      check("driverEn off", 32'(cfg.lineDriverEn), 32'(!i[0]));
    end
    setReg(IDX_TX0, 8'h00);
    for (int i = 0; i < 4; i++) begin
      setReg(IDX_TX1, {2'b00, i[1], i[0], tplCode[i]});
      check("tpl", 32'(cfg.tpl), 32'(tplExp[i]));
      check("dfmEnable", 32'(cfg.dfmEnable), 32'(!i[1]));
      check("driverEn float", 32'(cfg.lineDriverEn), 32'(!i[0]));
    end
    readChk(IDX_TX1, 8'h3f, "tx1 readback");
    setReg(IDX_TX0, 8'h06);
    lineEdge(1'b1, 2'b10, 1'b0, 1, 2'b10, "rise");
    lineEdge(1'b0, 2'b01, 1'b0, 0, 2'b00, "fall ignored");
    setReg(IDX_TX0, 8'h0a);
    lineEdge(1'b1, 2'b01, 1'b0, 0, 2'b00, "rise ignored");
    lineEdge(1'b0, 2'b01, 1'b0, 1, 2'b10, "fall inverted");
    setReg(IDX_TX0, 8'h00);
    lineEdge(1'b1, 2'b11, 1'b1, 1, 2'b01, "single rail");
    lineEdge(1'b0, 2'b11, 1'b0, 0, 2'b00, "single fall");
    setReg(IDX_TX0, 8'h16);
    lineEdge(1'b1, 2'b10, 1'b0, 0, 2'b00, "powered down");
    conclude();
  end
endmodule
